// File: rtl/hcocs_top.sv
`timescale 1ns/1ps
`default_nettype none
module hcocs_top #(
   parameter int TICK_CYCLES = hcocs_pkg::TICK_CYCLES_DEF
) (
   input wire logic clock,
   input wire logic reset_n,
   input wire hcocs_pkg::hcocs_av_req_t av_req,
   output logic av_waitrequest,
   output logic [31:0] av_readdata,
   input wire logic contact_input_one,
   input wire logic contact_input_two,
   output logic contact_output_one,
   output logic contact_output_two,
   output logic contact_output_three,
   output logic pulse_output,
   output logic [9:0] heat_output,
   output logic [9:0] cool_output,
   output logic [15:0] retransmit_value,
   output logic loop_power_enable,
   output logic key_lock_hidden,
   output logic run_stopped,
   output logic auto_mode
);
   import hcocs_pkg::*;

   localparam logic [18:0] TICK_LAST = 19'(TICK_CYCLES - 1);

   // percent helpers, tenths of a percent
   function automatic logic [9:0] cool_of(input logic [9:0] c);
      cool_of = (c < PCT_HALF) ? 10'((PCT_HALF - c) << 1) : 10'h000;
   endfunction : cool_of

   function automatic logic [9:0] heat_of(input logic [9:0] c);
      heat_of = (c > PCT_HALF) ? 10'((c - PCT_HALF) << 1) : 10'h000;
   endfunction : heat_of

   function automatic logic [9:0] clamp(input logic [9:0] v, input logic [9:0] lo, input logic [9:0] hi);
      clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction : clamp

   logic ack;
   logic req;
   logic wr_en;
   logic rd_cap;
   logic [31:0] ctrl;
   logic [9:0] compute;
   logic [15:0] pv;
   logic [15:0] remote_sp;
   logic [31:0] limits;
   logic [31:0] manpre;
   logic [7:0] cycle_time;
   logic [31:0] ramp;
   logic [2:0] alarms;
   logic [15:0] coolg;
   logic [15:0] sp_grp [4];
   logic [23:0] pid_grp [4];
   logic [18:0] tick_cnt;
   logic tick;
   logic [1:0] ci_meta;
   logic [1:0] ci_sync;
   logic [1:0] ci_prev;
   logic [1:0] ci_db;
   logic [2:0] db_cnt;
   hcocs_fc_t fc;
   hcocs_ot_t ot;
   hcocs_ret_t ret;
   logic [2:0] ci_sp;
   logic ci_am_ctl;
   logic ci_stop;
   logic ci_hide;
   logic stopped;
   logic is_auto;
   logic [2:0] sel;
   logic [1:0] grp;
   logic [15:0] raw_sp;
   logic [15:0] target;
   logic [18:0] ramp_acc;
   logic [18:0] unit_ticks;
   logic [19:0] acc_up;
   logic [19:0] acc_dn;
   logic [23:0] pid;
   logic heat_onoff;
   logic cool_onoff;
   logic integ_off;
   logic hc;
   logic tp;
   logic [9:0] mv;
   logic [9:0] next_mv;
   logic [9:0] next_heat;
   logic [9:0] next_cool;
   logic [14:0] per_cnt;
   logic [14:0] per_len;
   logic [14:0] on_ticks;
   logic [17:0] on_prod;

   // avalon slave: one wait cycle, then answer
   assign req = av_req.read | av_req.write;
   assign av_waitrequest = req & ~ack;
   assign wr_en = av_req.write & ack;
   assign rd_cap = av_req.read & ~ack;

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         ack <= 1'b0;
      end else begin
         ack <= req & ~ack;
      end
   end

   assign fc = hcocs_fc_t'(ctrl[FC_LSB +: 3]);
   assign ot = hcocs_ot_t'(ctrl[OT_LSB +: 2]);
   assign ret = hcocs_ret_t'(ctrl[RET_LSB +: 3]);
   assign hc = ctrl[HC_BIT];
   assign tp = (ot == OT_RELAY) || (ot == OT_VPULSE);

   // software written configuration
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         ctrl <= CTRL_RST;
         compute <= 10'h000;
         pv <= 16'h0000;
         remote_sp <= 16'h0000;
         limits <= LIMITS_RST;
         manpre <= 32'h0000_0000;
         ramp <= 32'h0000_0000;
         alarms <= 3'h0;
         coolg <= 16'h0000;
      end else if (wr_en) begin
         case (av_req.address)
            OFS_CTRL: ctrl <= av_req.writedata;
            OFS_COMPUTE: compute <= av_req.writedata[9:0];
            OFS_PV: pv <= av_req.writedata[15:0];
            OFS_REMOTE: remote_sp <= av_req.writedata[15:0];
            OFS_LIMITS: limits <= av_req.writedata;
            OFS_MANPRE: manpre <= av_req.writedata;
            OFS_RAMP: ramp <= av_req.writedata;
            OFS_ALARMS: alarms <= av_req.writedata[2:0];
            OFS_COOL: coolg <= av_req.writedata[15:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         cycle_time <= CYCLE_RST;
      end else if (wr_en && av_req.address == OFS_CYCLE && tp) begin
         cycle_time <= av_req.writedata[7:0];
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < 4; i++) begin
            sp_grp[i] <= 16'h0000;
            pid_grp[i] <= 24'h000000;
         end
      end else if (wr_en) begin
         for (int i = 0; i < 4; i++) begin
            if (av_req.address == OFS_SP_BASE + 8'(4 * i)) begin
               sp_grp[i] <= av_req.writedata[15:0];
            end
            if (av_req.address == OFS_PID_BASE + 8'(4 * i)) begin
               pid_grp[i] <= av_req.writedata[23:0];
            end
         end
      end
   end

   // time base tick
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         tick_cnt <= 19'h00000;
         tick <= 1'b0;
      end else begin
         tick <= (tick_cnt == TICK_LAST);
         tick_cnt <= (tick_cnt == TICK_LAST) ? 19'h00000 : tick_cnt + 19'h00001;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         ci_meta <= 2'h0;
         ci_sync <= 2'h0;
      end else begin
         ci_meta <= {contact_input_two, contact_input_one};
         ci_sync <= ci_meta;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         ci_prev <= 2'h0;
         ci_db <= 2'h0;
         db_cnt <= 3'h0;
      end else if (tick) begin
         ci_prev <= ci_sync;
         if (ci_sync != ci_prev) begin
            db_cnt <= 3'h0;
         end else if (db_cnt < DEBOUNCE_TICKS) begin
            db_cnt <= db_cnt + 3'h1;
         end else begin
            ci_db <= ci_prev;
         end
      end
   end

   // contact function decode
   always_comb begin
      ci_sp = 3'h0;
      ci_am_ctl = 1'b0;
      ci_stop = 1'b0;
      ci_hide = 1'b0;
      case (fc)
         FC_SP_AM: begin
            ci_sp = ci_db[0] ? 3'h2 : 3'h1;
            ci_am_ctl = 1'b1;
         end
         FC_LOCK: ci_hide = ci_db[0];
         FC_SP4: ci_sp = 3'h1 + {1'b0, ci_db[1], ci_db[0]};
         FC_SP_STOP: begin
            ci_sp = ci_db[0] ? 3'h2 : 3'h1;
            ci_stop = ci_db[1];
         end
         default: ci_sp = 3'h0;
      endcase
   end

   assign stopped = ctrl[STOP_BIT] | ci_stop;
   assign is_auto = ci_am_ctl ? ci_db[1] : ~ctrl[MAN_BIT];

   assign sel = (ci_sp != 3'h0) ? ci_sp : ctrl[SPSEL_LSB +: 3];
   assign grp = (sel > 3'h4) ? 2'h3 : 2'(sel - 3'h1);
   assign raw_sp = (sel == 3'h0) ? remote_sp : sp_grp[grp];
   assign pid = pid_grp[grp];

   assign unit_ticks = ctrl[TMU_BIT] ? TICKS_PER_HOUR : TICKS_PER_MIN;
   assign acc_up = {1'b0, ramp_acc} + {4'h0, ramp[15:0]};
   assign acc_dn = {1'b0, ramp_acc} + {4'h0, ramp[31:16]};

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         target <= 16'h0000;
         ramp_acc <= 19'h00000;
      end else if (tick) begin
         if (target < raw_sp) begin
            if (ramp[15:0] == 16'h0000) begin
               target <= raw_sp;
            end else if (acc_up >= {1'b0, unit_ticks}) begin
               target <= target + 16'h0001;
               ramp_acc <= 19'(acc_up - {1'b0, unit_ticks});
            end else begin
               ramp_acc <= acc_up[18:0];
            end
         end else if (target > raw_sp) begin
            if (ramp[31:16] == 16'h0000) begin
               target <= raw_sp;
            end else if (acc_dn >= {1'b0, unit_ticks}) begin
               target <= target - 16'h0001;
               ramp_acc <= 19'(acc_dn - {1'b0, unit_ticks});
            end else begin
               ramp_acc <= acc_dn[18:0];
            end
         end else begin
            ramp_acc <= 19'h00000;
         end
      end
   end

   assign heat_onoff = (pid[7:0] == 8'h00);
   assign cool_onoff = hc & (coolg[7:0] == 8'h00);
   assign integ_off = ~heat_onoff & ~cool_onoff & ((pid[15:8] == 8'h00) | (hc & coolg[15:8] == 8'h00));

   // unsplit output selection
   always_comb begin
      next_mv = clamp(compute, limits[9:0], limits[25:16]);
      if (!hc && heat_onoff) begin
         next_mv = (pv < target) ? PCT_FULL : 10'h000;
      end
      if (!is_auto) begin
         next_mv = manpre[9:0];
      end
      if (stopped) begin
         next_mv = manpre[25:16];
      end
   end

   // heating and cooling split
   always_comb begin
      next_heat = next_mv;
      next_cool = 10'h000;
      if (hc) begin
         next_cool = cool_of(next_mv);
         next_heat = heat_of(next_mv);
         if (is_auto && !stopped && heat_onoff) begin
            next_heat = (pv < target) ? PCT_FULL : 10'h000;
         end
         if (is_auto && !stopped && cool_onoff) begin
            next_cool = (pv > target) ? PCT_FULL : 10'h000;
         end
      end
   end

   // registered control outputs
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         mv <= 10'h000;
         heat_output <= 10'h000;
         cool_output <= 10'h000;
      end else begin
         mv <= next_mv;
         heat_output <= next_heat;
         cool_output <= next_cool;
      end
   end

   assign per_len = 15'(cycle_time) * 15'(TICKS_PER_SEC);
   assign on_prod = heat_output * cycle_time;

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         per_cnt <= 15'h0000;
         on_ticks <= 15'h0000;
         pulse_output <= 1'b0;
      end else begin
         pulse_output <= tp & (per_cnt < on_ticks);
         if (tick) begin
            if (per_cnt + 15'h0001 >= per_len) begin
               per_cnt <= 15'h0000;
               on_ticks <= 15'(on_prod / 18'd10);
            end else begin
               per_cnt <= per_cnt + 15'h0001;
            end
         end
      end
   end

   // status, retransmission and contact outputs
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         contact_output_one <= 1'b0;
         contact_output_two <= 1'b0;
         contact_output_three <= 1'b0;
         retransmit_value <= 16'h0000;
         loop_power_enable <= 1'b0;
         key_lock_hidden <= 1'b0;
         run_stopped <= 1'b0;
         auto_mode <= 1'b0;
      end else begin
         contact_output_one <= alarms[0];
         contact_output_two <= alarms[1];
         contact_output_three <= alarms[2];
         key_lock_hidden <= ci_hide;
         run_stopped <= stopped;
         auto_mode <= is_auto;
         loop_power_enable <= (ret == RET_LOOP);
         case (ret)
            RET_PV: retransmit_value <= pv;
            RET_SP: retransmit_value <= target;
            RET_OUT: retransmit_value <= {6'h00, mv};
            default: retransmit_value <= 16'h0000;
         endcase
      end
   end

   // read data captured in the wait cycle
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         av_readdata <= 32'h0000_0000;
      end else if (rd_cap) begin
         av_readdata <= 32'h0000_0000;
         case (av_req.address)
            OFS_CTRL: av_readdata <= ctrl;
            OFS_COMPUTE: av_readdata <= {22'h000000, compute};
            OFS_PV: av_readdata <= {16'h0000, pv};
            OFS_REMOTE: av_readdata <= {16'h0000, remote_sp};
            OFS_LIMITS: av_readdata <= limits;
            OFS_MANPRE: av_readdata <= manpre;
            OFS_CYCLE: av_readdata <= {24'h000000, cycle_time};
            OFS_RAMP: av_readdata <= ramp;
            OFS_ALARMS: av_readdata <= {29'h00000000, alarms};
            OFS_COOL: av_readdata <= {16'h0000, coolg};
            OFS_STATUS: av_readdata <= {16'h0000, ci_db, integ_off, cool_onoff, heat_onoff,
                                        pulse_output, auto_mode, run_stopped, key_lock_hidden, 4'h0, sel};
            OFS_TARGET: av_readdata <= {16'h0000, target};
            OFS_OUTPUTS: av_readdata <= {6'h00, cool_output, 6'h00, heat_output};
            OFS_RETX: av_readdata <= {15'h0000, loop_power_enable, retransmit_value};
            OFS_ACT_PID: av_readdata <= {8'h00, pid[23:16], integ_off ? 8'h00 : pid[15:8], pid[7:0]};
            default: begin
               for (int i = 0; i < 4; i++) begin
                  if (av_req.address == OFS_SP_BASE + 8'(4 * i)) begin
                     av_readdata <= {16'h0000, sp_grp[i]};
                  end
                  if (av_req.address == OFS_PID_BASE + 8'(4 * i)) begin
                     av_readdata <= {8'h00, pid_grp[i]};
                  end
               end
            end
         endcase
      end
   end
endmodule : hcocs_top
`default_nettype wire

// File: pkg/hcocs_pkg.sv
// Function
// - 0..50% result maps to full..zero cooling
// - 50..100% result maps to zero..full heating
// - zero proportional band selects on-off per side
// - either integral zero turns both integrals off
// - cycle time accepted only for pulse outputs
// - on then off phase fills each cycle
// - function code off ignores both contacts
// - code 1: setpoint 2/1 and auto/manual
// - code 2: contact one hides key lock
// - code 3: setpoint is 1+in1+2*in2
// - code 4: setpoint 2/1 and stop/run
// - stopped drives preset output, rest keeps running
// - stop overrides manual output
// - four setpoint and PID groups, selected
// - setpoint number zero uses remote setpoint
// - setpoint ramps limited up and down
// - alarms one to three drive contacts
// - retransmit type 4 gives loop power only
// - retransmit one selectable quantity
// - codes 1 PV, 2 SP, 3 OUT, 4 loop
package hcocs_pkg;
   localparam int CLK_HZ = 40_000_000;
   localparam int TICK_MS = 10;
   localparam int TICK_CYCLES_DEF = CLK_HZ / 1000 * TICK_MS;
   localparam int DEBOUNCE_MS = 20;
   localparam logic [2:0] DEBOUNCE_TICKS = 3'(DEBOUNCE_MS / TICK_MS);
   localparam logic [6:0] TICKS_PER_SEC = 7'(1000 / TICK_MS);
   localparam logic [18:0] TICKS_PER_MIN = 19'(60 * 1000 / TICK_MS);
   localparam logic [18:0] TICKS_PER_HOUR = 19'(3600 * 1000 / TICK_MS);
   localparam logic [9:0] PCT_FULL = 10'h3E8;
   localparam logic [9:0] PCT_HALF = 10'h1F4;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_COMPUTE = 8'h04;
   localparam logic [7:0] OFS_PV = 8'h08;
   localparam logic [7:0] OFS_REMOTE = 8'h0C;
   localparam logic [7:0] OFS_LIMITS = 8'h10;
   localparam logic [7:0] OFS_MANPRE = 8'h14;
   localparam logic [7:0] OFS_CYCLE = 8'h18;
   localparam logic [7:0] OFS_RAMP = 8'h1C;
   localparam logic [7:0] OFS_ALARMS = 8'h20;
   localparam logic [7:0] OFS_COOL = 8'h24;
   localparam logic [7:0] OFS_SP_BASE = 8'h30;
   localparam logic [7:0] OFS_PID_BASE = 8'h40;
   localparam logic [7:0] OFS_STATUS = 8'h50;
   localparam logic [7:0] OFS_TARGET = 8'h54;
   localparam logic [7:0] OFS_OUTPUTS = 8'h58;
   localparam logic [7:0] OFS_RETX = 8'h5C;
   localparam logic [7:0] OFS_ACT_PID = 8'h60;
   // control register fields
   localparam int FC_LSB = 0;
   localparam int OT_LSB = 3;
   localparam int RET_LSB = 5;
   localparam int HC_BIT = 8;
   localparam int TMU_BIT = 9;
   localparam int STOP_BIT = 10;
   localparam int MAN_BIT = 11;
   localparam int SPSEL_LSB = 12;
   // reset values
   localparam logic [31:0] CTRL_RST = 32'h0000_1029;
   localparam logic [31:0] LIMITS_RST = 32'h03E8_0000;
   localparam logic [7:0] CYCLE_RST = 8'h1E;
   typedef enum logic [2:0] {
      FC_OFF = 3'h0, FC_SP_AM = 3'h1, FC_LOCK = 3'h2, FC_SP4 = 3'h3, FC_SP_STOP = 3'h4
   } hcocs_fc_t;
   typedef enum logic [1:0] {
      OT_CURRENT = 2'h0, OT_RELAY = 2'h1, OT_VPULSE = 2'h2
   } hcocs_ot_t;
   typedef enum logic [2:0] {
      RET_PV = 3'h1, RET_SP = 3'h2, RET_OUT = 3'h3, RET_LOOP = 3'h4
   } hcocs_ret_t;
   typedef struct packed {
      logic read;
      logic write;
      logic [7:0] address;
      logic [31:0] writedata;
   } hcocs_av_req_t;
endpackage : hcocs_pkg

// File: dv/hcocs_field.sv
`timescale 1ns/1ps
`default_nettype none
module hcocs_field (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic want_one,
   input wire logic want_two,
   input wire logic pulse_output,
   output logic contact_input_one,
   output logic contact_input_two,
   output logic [31:0] on_len,
   output logic [31:0] per_len
);
   logic [31:0] run;
   logic last;
   // field switches held at the level asked for
   assign contact_input_one = want_one;
   assign contact_input_two = want_two;
   // relay load: length of last on phase and of last whole period
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         run <= 32'h0;
         last <= 1'b0;
         on_len <= 32'h0;
         per_len <= 32'h0;
      end else begin
         last <= pulse_output;
         run <= run + 32'h1;
         if (pulse_output && !last) begin
            per_len <= run;
            run <= 32'h1;
         end
         if (!pulse_output && last) begin
            on_len <= run;
         end
      end
   end
endmodule : hcocs_field
`default_nettype wire

// File: dv/hcocs_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module hcocs_monitor #(
   parameter int TICK_CYCLES = 20
) (
   input wire logic clock,
   input wire logic reset_n,
   input wire hcocs_pkg::hcocs_av_req_t av_req,
   input wire logic av_waitrequest,
   input wire logic [31:0] av_readdata,
   input wire logic contact_input_one,
   input wire logic contact_output_one,
   input wire logic contact_output_two,
   input wire logic contact_output_three,
   input wire logic [9:0] heat_output,
   input wire logic [9:0] cool_output,
   input wire logic [15:0] retransmit_value,
   input wire logic loop_power_enable,
   input wire logic key_lock_hidden
);
   import hcocs_pkg::*;
   logic req;
   logic acc_alarm;
   logic acc_ctrl;
   // accepted bus writes by target
   assign req = av_req.read | av_req.write;
   assign acc_alarm = av_req.write & ~av_waitrequest & (av_req.address == OFS_ALARMS);
   assign acc_ctrl = av_req.write & ~av_waitrequest & (av_req.address == OFS_CTRL);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!reset_n);
   a_wait_one: assert property ($rose(req) |-> av_waitrequest ##1 !av_waitrequest)
      else $error("waitrequest not exactly one cycle");
   a_unmap_zero: assert property (av_req.read && !av_waitrequest && av_req.address == 8'h2C |-> av_readdata == 32'h0)
      else $error("unmapped read not zero");
   a_alarm_route: assert property (acc_alarm |-> ##2
      {contact_output_three, contact_output_two, contact_output_one} == $past(av_req.writedata[2:0], 2))
      else $error("alarm contacts do not follow write");
   a_split_excl: assert property (cool_output != 10'h0 |-> heat_output == 10'h0)
      else $error("heating and cooling both active");
   a_out_range: assert property (heat_output <= PCT_FULL && cool_output <= PCT_FULL)
      else $error("output above full scale");
   a_loop_excl: assert property (loop_power_enable |-> retransmit_value == 16'h0)
      else $error("loop power with retransmit value");
   a_loop_cause: assert property ($changed(loop_power_enable) |-> $past(acc_ctrl) || $past(acc_ctrl, 2))
      else $error("loop power changed without control write");
   a_lock_synced: assert property ($rose(key_lock_hidden) |-> $past(contact_input_one, 4) || $past(acc_ctrl, 2))
      else $error("lock hide without settled contact");
endmodule : hcocs_monitor
bind hcocs_top hcocs_monitor #(.TICK_CYCLES(TICK_CYCLES)) hcocs_monitor_inst (.clock(clock), .reset_n(reset_n),
   .av_req(av_req), .av_waitrequest(av_waitrequest), .av_readdata(av_readdata),
   .contact_input_one(contact_input_one), .contact_output_one(contact_output_one),
   .contact_output_two(contact_output_two), .contact_output_three(contact_output_three),
   .heat_output(heat_output), .cool_output(cool_output), .retransmit_value(retransmit_value),
   .loop_power_enable(loop_power_enable), .key_lock_hidden(key_lock_hidden));
`default_nettype wire

// File: dv/hcocs_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module hcocs_top_tb;
   import hcocs_pkg::*;
   localparam int TK = 20;
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   hcocs_av_req_t av_req = '0;
   logic want_one = 1'b0;
   logic want_two = 1'b0;
   logic ci_one, ci_two, wait_r, do1, do2, do3, pulse, loop_en, lock_h, stopped, auto_m;
   logic [31:0] rdata, q, on_len, per_len;
   logic [9:0] heat, cool;
   logic [15:0] retx;
   int err_total = 0;
   int checks_done = 0;
   // 25 ns clock
   always #12.5 clock = ~clock;
   hcocs_top #(.TICK_CYCLES(TK)) hcocs_top_inst (.clock(clock), .reset_n(reset_n), .av_req(av_req),
      .av_waitrequest(wait_r), .av_readdata(rdata), .contact_input_one(ci_one), .contact_input_two(ci_two),
      .contact_output_one(do1), .contact_output_two(do2), .contact_output_three(do3), .pulse_output(pulse),
      .heat_output(heat), .cool_output(cool), .retransmit_value(retx), .loop_power_enable(loop_en),
      .key_lock_hidden(lock_h), .run_stopped(stopped), .auto_mode(auto_m));
   hcocs_field hcocs_field_inst (.clock(clock), .reset_n(reset_n), .want_one(want_one), .want_two(want_two),
      .pulse_output(pulse), .contact_input_one(ci_one), .contact_input_two(ci_two), .on_len(on_len),
      .per_len(per_len));
   task automatic conclude;
      if (err_total == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : conclude
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   function automatic logic [31:0] ctrl(input logic [2:0] fc, input logic [1:0] ot, input logic [2:0] ret,
      input logic hc, input logic stp, input logic man, input logic [2:0] sp);
      ctrl = {17'h0, sp, man, stp, 1'b0, hc, ret, ot, fc};
   endfunction : ctrl
   // one bus cycle, held until waitrequest is sampled low at a rising edge
   task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock);
      av_req <= '{read: rd, write: ~rd, address: a, writedata: d};
      do begin
         @(posedge clock);
         n++;
      end while (wait_r !== 1'b0 && n < 40);
      q = rdata;
      if (n >= 40) begin
         err_total++;
         $display("BAD %0t bus timeout", $time);
         conclude();
      end
      av_req <= '0;
   endtask : bus
   task automatic settle(input int n);
      repeat (n) @(posedge clock);
      @(negedge clock);
   endtask : settle
   task automatic pins(input logic a, input logic b);
      @(posedge clock);
      want_one <= a;
      want_two <= b;
   endtask : pins
   task automatic wait_ret(input logic [15:0] e);
      int n;
      n = 0;
      while (retx !== e && n < 3000) begin
         @(negedge clock);
         n++;
      end
      check({16'h0, retx}, {16'h0, e});
      if (retx !== e) begin
         conclude();
      end
   endtask : wait_ret
   // reset values, cycle time acceptance, unmapped place
   task automatic t_regs;
      bus(1'b1, OFS_CTRL, 32'h0);
      check(q, ctrl(3'h1, 2'h1, 3'h1, 1'b0, 1'b0, 1'b0, 3'h1));
      bus(1'b1, OFS_CYCLE, 32'h0);
      check(q, 32'h0000_001E);
      bus(1'b0, OFS_CYCLE, 32'h1);
      bus(1'b1, OFS_CYCLE, 32'h0);
      check(q, 32'h1);
      bus(1'b0, OFS_CTRL, ctrl(3'h0, 2'h0, 3'h1, 1'b0, 1'b0, 1'b1, 3'h1));
      bus(1'b0, OFS_CYCLE, 32'h5);
      bus(1'b1, OFS_CYCLE, 32'h0);
      check(q, 32'h1);
      bus(1'b0, 8'h2C, 32'hFFFF_FFFF);
      bus(1'b1, 8'h2C, 32'h0);
      check(q, 32'h0);
   endtask : t_regs
   // manual sweep in heating/cooling mode with contacts ignored
   task automatic t_split;
      int m;
      pins(1'b1, 1'b1);
      bus(1'b0, OFS_CTRL, ctrl(3'h0, 2'h1, 3'h3, 1'b1, 1'b0, 1'b1, 3'h1));
      // heating band 40 against cooling band 10
      bus(1'b0, OFS_PID_BASE, 32'h0000_0028);
      bus(1'b0, OFS_COOL, 32'h0000_000A);
      for (int i = 0; i < 5; i++) begin
         m = i * 250;
         bus(1'b0, OFS_MANPRE, 32'(m));
         settle(4);
         check({22'h0, cool}, 32'(m < 500 ? (500 - m) * 2 : 0));
         check({22'h0, heat}, 32'(m > 500 ? (m - 500) * 2 : 0));
         check({16'h0, retx}, 32'(m));
      end
      settle(150);
      bus(1'b1, OFS_STATUS, 32'h0);
      check({29'h0, q[2:0]}, 32'h1);
      check({29'h0, q[13:11]}, 32'h4);
   endtask : t_split
   // contact functions for each code
   task automatic t_codes;
      pins(1'b0, 1'b0);
      bus(1'b0, OFS_CTRL, ctrl(3'h2, 2'h1, 3'h4, 1'b0, 1'b0, 1'b1, 3'h1));
      settle(150);
      pins(1'b1, 1'b0);
      settle(4);
      check({31'h0, lock_h}, 32'h0);
      pins(1'b0, 1'b0);
      settle(150);
      check({31'h0, lock_h}, 32'h0);
      check({15'h0, loop_en, retx}, 32'h0001_0000);
      pins(1'b1, 1'b0);
      settle(150);
      check({31'h0, lock_h}, 32'h1);
      bus(1'b0, OFS_CTRL, ctrl(3'h1, 2'h1, 3'h1, 1'b0, 1'b0, 1'b0, 3'h1));
      pins(1'b1, 1'b1);
      settle(150);
      bus(1'b1, OFS_STATUS, 32'h0);
      check({28'h0, auto_m, q[2:0]}, 32'hA);
      pins(1'b0, 1'b0);
      settle(150);
      bus(1'b1, OFS_STATUS, 32'h0);
      check({28'h0, auto_m, q[2:0]}, 32'h1);
      bus(1'b0, OFS_CTRL, ctrl(3'h3, 2'h1, 3'h1, 1'b0, 1'b0, 1'b1, 3'h1));
      for (int k = 0; k < 4; k++) begin
         pins(k[0], k[1]);
         settle(150);
         bus(1'b1, OFS_STATUS, 32'h0);
         check({29'h0, q[2:0]}, 32'(k + 1));
      end
      bus(1'b0, OFS_MANPRE, {6'h0, 10'h064, 6'h0, 10'h320});
      bus(1'b0, OFS_CTRL, ctrl(3'h4, 2'h1, 3'h1, 1'b0, 1'b0, 1'b1, 3'h1));
      pins(1'b1, 1'b1);
      settle(150);
      bus(1'b0, OFS_ALARMS, 32'h5);
      settle(3);
      check({28'h0, stopped, do3, do2, do1}, 32'hD);
      check({22'h0, heat}, 32'h064);
      bus(1'b1, OFS_STATUS, 32'h0);
      check({29'h0, q[2:0]}, 32'h2);
      pins(1'b0, 1'b0);
      settle(150);
      check({21'h0, stopped, heat}, 32'h320);
   endtask : t_codes
   // stored groups and remote target on retransmission
   task automatic t_group;
      for (int g = 0; g < 4; g++) begin
         bus(1'b0, OFS_SP_BASE + 8'(4 * g), 32'(10 * (g + 1)));
      end
      for (int g = 0; g < 4; g++) begin
         bus(1'b0, OFS_CTRL, ctrl(3'h0, 2'h1, 3'h2, 1'b0, 1'b0, 1'b1, 3'(g + 1)));
         wait_ret(16'(10 * (g + 1)));
      end
      bus(1'b0, OFS_REMOTE, 32'h19);
      bus(1'b0, OFS_CTRL, ctrl(3'h0, 2'h1, 3'h2, 1'b0, 1'b0, 1'b1, 3'h0));
      wait_ret(16'h0019);
      // upward ramp of one count per tick
      bus(1'b0, OFS_RAMP, 32'h0000_1770);
      bus(1'b0, OFS_CTRL, ctrl(3'h0, 2'h1, 3'h2, 1'b0, 1'b0, 1'b1, 3'h4));
      settle(100);
      check({31'h0, retx < 16'h0028}, 32'h1);
      wait_ret(16'h0028);
   endtask : t_group
   // half output over a one second cycle
   task automatic t_pulse;
      bus(1'b0, OFS_CTRL, ctrl(3'h0, 2'h1, 3'h1, 1'b0, 1'b0, 1'b1, 3'h1));
      bus(1'b0, OFS_MANPRE, 32'h1F4);
      settle(4500);
      check(on_len, 32'(500 / 10 * TK));
      check(per_len, 32'(100 * TK));
   endtask : t_pulse
   // main sequence
   initial begin
      repeat (10) @(posedge clock);
      reset_n <= 1'b1;
      t_regs();
      t_split();
      t_codes();
      t_group();
      t_pulse();
      conclude();
   end
endmodule : hcocs_top_tb
`default_nettype wire
